// ===== rtl/dcw_clock_ctrl.sv
// Clock select, periodic dividers and watchdog with a Wishbone register slave
`timescale 1ns/100ps
`default_nettype none
`include "dcw_cfg.svh"

module dcw_clock_ctrl
  import dcw_pkg::*;
#(
  parameter bit WDT_PRESENT = 1'b1
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Oscillator pins
  input wire logic main_osc_clock,
  input wire logic sub_osc_clock,
  input wire logic stop_mode,
  output logic main_osc_enable,
  output logic display_clock,
  // Core side
  output logic interrupt_request,
  output logic hold_release,
  output logic chip_reset
);

  dcw_state_t q;
  dcw_state_t d;

  // Filtered level and rising edge of a three-stage synchronised pin
  function automatic logic [1:0] pin_edge(input logic [2:0] s,
                                          input logic lev);
    logic nl;
    nl = (s[1] == s[2]) ? s[2] : lev;
    pin_edge = {nl & ~lev, nl};
  endfunction

  logic [1:0] m_pe;
  logic [1:0] s_pe;
  logic m_edge;
  logic s_edge;
  logic fosc_tick;
  logic src_req;
  logic req;
  logic wr;
  logic div0_ovf;
  logic div1_ovf;
  logic wdt_tick;
  logic wdt_ovf;
  logic [7:0] evf_set;
  logic [7:0] evf_clr;
  logic [3:0] cmd;

  always_comb
  begin
    d = q;
    m_pe = pin_edge(q.main_sync, q.main_lev);
    s_pe = pin_edge(q.sub_sync, q.sub_lev);
    m_edge = m_pe[1];
    s_edge = s_pe[1];
    d.main_sync = {q.main_sync[1:0], main_osc_clock};
    d.sub_sync = {q.sub_sync[1:0], sub_osc_clock};
    d.main_lev = m_pe[0];
    d.sub_lev = s_pe[0];

    // Bus access; strobes act at the edge where ack rises
    req = wb_cyc_i & wb_stb_i & ~q.ack;
    wr = req & wb_we_i & wb_sel_i[0];
    d.ack = req;
    cmd = 4'h0;
    evf_clr = 8'h00;
    if (wr)
    begin
      case (wb_adr_i[4:2])
        `DCW_OFS_CLK_SEL: d.sel = wb_dat_i[3:0];
        `DCW_OFS_EVENT: evf_clr = wb_dat_i[7:0];
        `DCW_OFS_INT_EN: d.interrupt_enable_flags = wb_dat_i[7:0];
        `DCW_OFS_HOLD_EN: d.hold_release_enable_flags = wb_dat_i[7:0];
        `DCW_OFS_COMMAND: cmd = wb_dat_i[3:0];
        default: cmd = 4'h0;
      endcase
    end
    d.rdat = 32'h0000_0000;
    if (req && !wb_we_i)
    begin
      case (wb_adr_i[4:2])
        `DCW_OFS_CLK_SEL: d.rdat = {28'h0000_000, q.sel};
        `DCW_OFS_EVENT: d.rdat = {24'h00_0000, q.event_flags};
        `DCW_OFS_INT_EN: d.rdat = {24'h00_0000, q.interrupt_enable_flags};
        `DCW_OFS_HOLD_EN: d.rdat = {24'h00_0000, q.hold_release_enable_flags};
        `DCW_OFS_STATUS: d.rdat = {27'h000_0000, q.src, q.wdt};
        default: d.rdat = 32'h0000_0000;
      endcase
    end

    // Source changes only on an edge of the new source, so no short tick
    src_req = q.sel[`DCW_SEL_SRC];
    fosc_tick = 1'b0;
    case (q.src)
      DCW_SRC_MAIN:
      begin
        if (src_req)
        begin
          fosc_tick = s_edge;
          if (s_edge)
            d.src = DCW_SRC_SUB;
        end
        else
          fosc_tick = m_edge;
      end
      DCW_SRC_SUB:
      begin
        if (!src_req)
        begin
          fosc_tick = m_edge;
          if (m_edge)
            d.src = DCW_SRC_MAIN;
        end
        else
          fosc_tick = s_edge;
      end
      default: d.src = DCW_SRC_MAIN;
    endcase
    d.main_osc_en = ~q.sel[`DCW_SEL_MAIN_STOP];
    d.disp_clk = q.sub_lev & ~stop_mode;

    // Fast divider: full 14-bit wrap gives 500 ms at 32.768 kHz
    div0_ovf = fosc_tick && (&q.div0);
    if (fosc_tick)
      d.div0 = q.div0 + 14'h0001;
    if (cmd[`DCW_CMD_CLR_DIV0])
      d.div0[13:10] = 4'h0;

    // Slow divider: 13 bits for 250 ms, 12 bits for 125 ms
    if (q.sel[`DCW_SEL_DIV1_SHORT])
      div1_ovf = s_edge && (&q.div1[11:0]);
    else
      div1_ovf = s_edge && (&q.div1);
    if (s_edge)
      d.div1 = div1_ovf ? 13'h0000 : q.div1 + 13'h0001;
    if (cmd[`DCW_CMD_CLR_DIV1])
    begin
      if (q.sel[`DCW_SEL_DIV1_SHORT])
        d.div1[12:8] = 5'h00;
      else
        d.div1[12:9] = 4'h0;
    end

    // Event flags: hardware set wins over software clear
    evf_set = 8'h00;
    evf_set[`DCW_EVF_DIV0] = div0_ovf;
    evf_set[`DCW_EVF_DIV1] = div1_ovf;
    d.event_flags = (q.event_flags & ~evf_clr) | evf_set;
    d.irq = |(d.event_flags & q.interrupt_enable_flags);
    d.hold_rel = |(d.event_flags & q.hold_release_enable_flags);

    // Watchdog prescaler and counter
    if (fosc_tick)
      d.pre = q.pre + 14'h0001;
    if (q.sel[`DCW_SEL_WDT_SLOW])
      wdt_tick = fosc_tick && (&q.pre);
    else
      wdt_tick = fosc_tick && (&q.pre[9:0]);
    wdt_ovf = WDT_PRESENT && wdt_tick && (&q.wdt);
    if (!WDT_PRESENT || cmd[`DCW_CMD_WATCHDOG_CLEAR_INSTR])
      d.wdt = 4'h0;
    else if (wdt_tick)
      d.wdt = q.wdt + 4'h1;
    d.chip_rst = wdt_ovf;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.sel <= `DCW_SEL_RESET;
      q.src <= DCW_SRC_MAIN;
      q.main_osc_en <= 1'b1;
    end
    else
      q <= d;
  end

  assign wb_dat_o = q.rdat;
  assign wb_ack_o = q.ack;
  assign main_osc_enable = q.main_osc_en;
  assign display_clock = q.disp_clk;
  assign interrupt_request = q.irq;
  assign hold_release = q.hold_rel;
  assign chip_reset = q.chip_rst;

  // Register bus handshake
  AST_ACK_ONE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  AST_ACK_REQ: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered in the next cycle");

  AST_ACK_IDLE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");

  AST_RDAT_IDLE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");

  AST_SEL_WRITE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (wr && wb_adr_i[4:2] == `DCW_OFS_CLK_SEL)
      |=> q.sel == $past(wb_dat_i[3:0]))
    else $error("clock select write lost");

  // Fast divider
  AST_DIV0_EVF: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    div0_ovf |=> q.event_flags[0] && q.div0 == 14'h0000)
    else $error("fast divider overflow did not set flag 0");

  AST_DIV0_STEP: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (fosc_tick && !cmd[0]) |=> q.div0 == $past(q.div0) + 14'h0001)
    else $error("fast divider did not advance");

  AST_DIV0_IDLE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (!fosc_tick && !cmd[0]) |=> $stable(q.div0))
    else $error("fast divider moved without a tick");

  AST_DIV0_CLR: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    cmd[0] |=> q.div0[13:10] == 4'h0)
    else $error("fast divider top stages not cleared");

  AST_EVF0_KEEP: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (q.event_flags[0] && !evf_clr[0]) |=> q.event_flags[0])
    else $error("flag 0 lost without a clear");

  // Slow divider
  AST_DIV1_EVF: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    div1_ovf |=> q.event_flags[4] && q.div1 == 13'h0000)
    else $error("slow divider overflow did not set flag 4");

  AST_DIV1_STEP: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (s_edge && !div1_ovf && !cmd[1]) |=> q.div1 == $past(q.div1) + 13'h0001)
    else $error("slow divider did not advance");

  AST_DIV1_IDLE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (!s_edge && !cmd[1]) |=> $stable(q.div1))
    else $error("slow divider moved without a sub tick");

  AST_DIV1_SHORT: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (s_edge && q.sel[3] && q.div1[11:0] == 12'hFFF) |-> div1_ovf)
    else $error("short slow period did not wrap at 12 bits");

  AST_DIV1_CLR: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    cmd[1] |=> q.div1[12:9] == 4'h0)
    else $error("slow divider top stages not cleared");

  AST_EVF4_KEEP: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (q.event_flags[4] && !evf_clr[4]) |=> q.event_flags[4])
    else $error("flag 4 lost without a clear");

  AST_EVF4_CLR: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (evf_clr[4] && !evf_set[4]) |=> !q.event_flags[4])
    else $error("flag 4 not cleared");

  // Watchdog
  AST_PRE_STEP: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    fosc_tick |=> q.pre == $past(q.pre) + 14'h0001)
    else $error("watchdog prescaler did not advance");

  AST_WDT_STEP: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (WDT_PRESENT && wdt_tick && !cmd[2]) |=> q.wdt == $past(q.wdt) + 4'h1)
    else $error("watchdog did not advance");

  AST_WDT_IDLE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (WDT_PRESENT && !wdt_tick && !cmd[2]) |=> $stable(q.wdt))
    else $error("watchdog moved without a tick");

  AST_WDT_CLR: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    cmd[2] |=> q.wdt == 4'h0)
    else $error("watchdog not cleared");

  AST_WDT_RST: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (wdt_tick && q.wdt == 4'hF && !cmd[2]) |=> chip_reset ##1 !chip_reset)
    else $error("watchdog overflow did not pulse chip reset");

  AST_RST_CAUSE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    chip_reset |-> $past(wdt_ovf))
    else $error("chip reset without watchdog overflow");

  // Oscillators, source and display
  AST_OSC_STOP: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    q.sel[1] |=> !main_osc_enable)
    else $error("main oscillator not stopped");

  AST_OSC_RUN: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !q.sel[1] |=> main_osc_enable)
    else $error("main oscillator not running");

  AST_DISP_OFF: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    stop_mode |=> !display_clock)
    else $error("display clock running in stop mode");

  AST_DISP_SRC: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    display_clock |-> $past(q.sub_lev))
    else $error("display clock not from sub oscillator");

  AST_SRC_EDGE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (q.src != $past(q.src)) |-> $past(fosc_tick))
    else $error("clock source changed without a fresh edge");

  AST_SRC_SUB_HOLD: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (q.src == DCW_SRC_SUB && q.sel[0]) |=> q.src == DCW_SRC_SUB)
    else $error("sub source left while selected");

  AST_SRC_MAIN_HOLD: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (q.src == DCW_SRC_MAIN && !q.sel[0]) |=> q.src == DCW_SRC_MAIN)
    else $error("main source left while selected");

endmodule
`default_nettype wire

// ===== rtl/dcw_cfg.svh
// Constants for the dual clock divider and watchdog block
//
// Overview of operation
// - Fast divider is a 14-bit up-counter advancing on every system clock tick.
// - Fast divider overflow sets event flag 0, gated to interrupt and hold release.
// - Clear-fast-divider command zeroes the top four stages of the fast divider.
// - With a 32.768 kHz system clock the fast flag sets every 500 ms.
// - Slow divider counts 13 or 12 bits, clocked only by sub oscillator ticks.
// - Slow divider overflow sets event flag 4, gated to interrupt and hold release.
// - Clear-slow-divider command zeroes the top four stages of the slow divider.
// - Clock select bit 3 picks slow period: 0 gives 250 ms, 1 gives 125 ms.
// - Clock select bit 0 picks system clock: 0 main oscillator, 1 sub oscillator.
// - Clock select bit 1 set stops the main oscillator.
// - Display clock always comes from sub oscillator and is off in stop mode.
// - Watchdog is a 4-bit up-counter whose overflow resets the whole chip.
// - Watchdog presence is a build-time option, not a runtime setting.
// - Watchdog ticks at system clock over 1024, or over 16384 with select bit 2.
// - Watchdog clear command resets the watchdog counter to zero.
// - At 32 kHz and divide by 1024 the watchdog overflows after about 500 ms.
`ifndef DCW_CFG_SVH
`define DCW_CFG_SVH

// Register word indices, decoded from address bits 4:2
`define DCW_OFS_CLK_SEL 3'h0
`define DCW_OFS_EVENT 3'h1
`define DCW_OFS_INT_EN 3'h2
`define DCW_OFS_HOLD_EN 3'h3
`define DCW_OFS_COMMAND 3'h4
`define DCW_OFS_STATUS 3'h5

// Clock select fields
`define DCW_SEL_SRC 0
`define DCW_SEL_MAIN_STOP 1
`define DCW_SEL_WDT_SLOW 2
`define DCW_SEL_DIV1_SHORT 3
`define DCW_SEL_RESET 4'h0

// Command fields
`define DCW_CMD_CLR_DIV0 0
`define DCW_CMD_CLR_DIV1 1
`define DCW_CMD_WATCHDOG_CLEAR_INSTR 2

// Event flag positions
`define DCW_EVF_DIV0 0
`define DCW_EVF_DIV1 4

// Widths and ratios
`define DCW_DIV0_BITS 14
`define DCW_DIV1_LONG 13
`define DCW_DIV1_SHORT 12
`define DCW_WDT_BITS 4
`define DCW_WDT_FAST_RATIO 1024
`define DCW_WDT_SLOW_RATIO 16384

`endif

// ===== rtl/dcw_pkg.sv
// Types for the dual clock divider and watchdog block
package dcw_pkg;

  typedef enum logic {DCW_SRC_MAIN, DCW_SRC_SUB} dcw_src_t;

  typedef struct packed {
    logic [2:0] main_sync;
    logic [2:0] sub_sync;
    logic main_lev;
    logic sub_lev;
    logic [3:0] sel;
    dcw_src_t src;
    logic [13:0] div0;
    logic [12:0] div1;
    logic [13:0] pre;
    logic [3:0] wdt;
    logic [7:0] event_flags;
    logic [7:0] interrupt_enable_flags;
    logic [7:0] hold_release_enable_flags;
    logic ack;
    logic [31:0] rdat;
    logic irq;
    logic hold_rel;
    logic chip_rst;
    logic main_osc_en;
    logic disp_clk;
  } dcw_state_t;

endpackage

// ===== bench/tb_dual_clock_divider_watchdog.sv
// Self-checking testbench for the clock control block
`timescale 1ns/100ps
`default_nettype none
module tb_dual_clock_divider_watchdog;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic stop_mode = 1'b0;
  logic mclk = 1'b0;
  logic sclk = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [4:0] adr = 5'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rd;
  logic [31:0] dat_o;
  logic ack, osc_en, disp, irq, hold, crst;
  logic [1:0] ph = 2'h0;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc_cnt = 0;
  int n;

  always #20 sys_clk = ~sys_clk;

  dcw_clock_ctrl i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .main_osc_clock(mclk), .sub_osc_clock(sclk), .stop_mode(stop_mode),
    .main_osc_enable(osc_en), .display_clock(disp),
    .interrupt_request(irq), .hold_release(hold), .chip_reset(crst));

  // Pin clocks of six cycles; the main one stands still while stopped
  always @(posedge sys_clk)
  begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    if (ph == 2'h2)
    begin
      sclk <= ~sclk;
      if (osc_en)
        mclk <= ~mclk;
    end
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 60000)
    begin
      error_cnt = error_cnt + 1;
      results();
    end
  end

  task automatic chk(input string name, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks = num_checks + 1;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", name, e, g);
      error_cnt = error_cnt + 1;
    end
  endtask

  // One classic cycle; waits for ack, then releases
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k == 20)
      chk("ack", 32'h1, 32'h0);
  endtask

  task automatic ticks(input int t);
    repeat (t * 6) @(posedge sys_clk);
  endtask

  task automatic t_reset();
    wb(1'b0, 5'h00, 32'h0);
    chk("clk_sel", 32'h0, rd);
    chk("main_osc_enable", 32'h1, {31'h0, osc_en});
    wb(1'b0, 5'h18, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask

  task automatic t_switch();
    wb(1'b1, 5'h00, 32'h1);
    ticks(4);
    wb(1'b0, 5'h14, 32'h0);
    chk("src sub", 32'h1, {31'h0, rd[4]});
    wb(1'b1, 5'h00, 32'h3);
    ticks(1);
    chk("main stopped", 32'h0, {31'h0, osc_en});
    wb(1'b1, 5'h00, 32'h1);
    ticks(4);
    chk("main restarted", 32'h1, {31'h0, osc_en});
    wb(1'b1, 5'h00, 32'h0);
    ticks(4);
    wb(1'b0, 5'h14, 32'h0);
    chk("src main", 32'h0, {31'h0, rd[4]});
  endtask

  task automatic t_slow();
    wb(1'b1, 5'h00, 32'h8);
    wb(1'b1, 5'h08, 32'h10);
    wb(1'b1, 5'h0C, 32'h10);
    wb(1'b1, 5'h10, 32'h2);
    wb(1'b1, 5'h04, 32'hFF);
    n = 0;
    while (irq !== 1'b1 && n < 30000)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk("slow period", 32'h1, {31'h0, n >= 23040 && n <= 24612});
    wb(1'b0, 5'h04, 32'h0);
    chk("event_flags", 32'h10, rd);
    chk("hold_release", 32'h1, {31'h0, hold});
    wb(1'b1, 5'h04, 32'h10);
    ticks(1);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask

  task automatic t_wdt();
    wb(1'b1, 5'h10, 32'h4);
    wb(1'b0, 5'h14, 32'h0);
    chk("wdt cleared", 32'h0, {28'h0, rd[3:0]});
    ticks(2048);
    wb(1'b0, 5'h14, 32'h0);
    chk("wdt by 1024", 32'h2, {28'h0, rd[3:0]});
    wb(1'b1, 5'h00, 32'h4);
    wb(1'b1, 5'h10, 32'h4);
    ticks(2048);
    wb(1'b0, 5'h14, 32'h0);
    chk("wdt by 16384", 32'h0, {28'h0, rd[3:0]});
    chk("no chip reset", 32'h0, {31'h0, crst});
  endtask

  task automatic t_disp();
    int hi;
    hi = 0;
    stop_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    repeat (24) @(posedge sys_clk) hi = hi | disp;
    chk("display off", 32'h0, hi);
    stop_mode <= 1'b0;
    hi = 0;
    repeat (24) @(posedge sys_clk) hi = hi | disp;
    chk("display runs", 32'h1, hi);
  endtask

  task automatic results();
    if (error_cnt == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_switch();
    t_slow();
    t_wdt();
    t_disp();
    results();
  end
endmodule
`default_nettype wire
